// ---- design/ccb_master.sv ----
// processor card bus master: clocks, buffers, strobes, power-on jump
//
// Operation
// RQ1 - after power-on clear, start at a switch-chosen 4K boundary instead of zero
// RQ2 - four switch positions give start address bits fifteen to twelve
// RQ3 - fifth switch position enables the jump; when off, address switches ignored
// RQ4 - jump circuit puts start address on internal data bus for fetch
// RQ5 - one 8 MHz reference feeds processor clock and every bus timing output
// RQ6 - drive 2 MHz bus clock, high time 40 to 60 percent
// RQ7 - drive 4 MHz phase two as master bus timing reference
// RQ8 - each serial port gets own reference, divided to programmed line rate
// RQ9 - sixteen address lines reach bus through releasable tri-state buffers
// RQ10 - 8-bit bidirectional internal data path, buffered to data-in and data-out
// RQ11 - assert pSYNC at the start of each machine cycle
// RQ12 - write strobe low only while valid write data sits on data-out
// RQ13 - pDBIN requests read data; slave drives data-in meanwhile
// RQ14 - on hold request release bus and assert pHLDA
// RQ15 - assert MWRT during memory write cycles
// RQ16 - bus control outputs come from registered latches
// RQ17 - asterisk-named signals are active low on both sides
// RQ18 - temporary master requests the bus by asserting hold
// RQ19 - reset request or power-up gives power-on clear to bus and jump circuit
// RQ20 - jump target holds switch value above twelve zero bits
`timescale 1ns/1ps
`default_nettype none

module ccb_master
  import ccb_pkg::*;
#(
  parameter int unsigned POC_HOLD = POC_CYCLES
) (
  input  wire logic              i_clock,
  input  wire logic              i_nrst,
  // bus reset request and power-on clear
  input  wire logic              i_reset_req_n,
  output logic                   o_poc_n,
  // option switch and serial divisors
  input  wire logic [SW_W-1:0]   i_jump_option_switch,
  input  wire logic [BAUD_CW-1:0] i_sp1_divisor,
  input  wire logic [BAUD_CW-1:0] i_sp2_divisor,
  // timing outputs
  output logic                   o_bus_clock,
  output logic                   o_phase2,
  output logic                   o_cpu_phi,
  output logic                   o_cpu_clk_en,
  output logic                   o_serial_port_one_timing_ref,
  output logic                   o_serial_port_two_timing_ref,
  output logic                   o_sp1_rate_tick,
  output logic                   o_sp2_rate_tick,
  // processor side
  output logic                   o_cpu_reset_n,
  input  wire logic [ADDR_W-1:0] i_cpu_addr,
  input  wire logic [DATA_W-1:0] i_cpu_dout,
  input  wire logic              i_cpu_dout_oe,
  output logic [DATA_W-1:0]      o_cpu_din,
  input  wire logic              i_cpu_mreq_n,
  input  wire logic              i_cpu_iorq_n,
  input  wire logic              i_cpu_rd_n,
  input  wire logic              i_cpu_wr_n,
  input  wire logic              i_cpu_busak_n,
  output logic                   o_cpu_busrq_n,
  // backplane side
  output logic [ADDR_W-1:0]      o_addr,
  output logic                   o_addr_oe,
  input  wire logic [DATA_W-1:0] i_di,
  output logic [DATA_W-1:0]      o_do,
  output logic                   o_do_oe,
  output logic                   o_ctl_oe,
  output logic                   o_psync,
  output logic                   o_pwr_n,
  output logic                   o_pdbin,
  output logic                   o_mwrt,
  output logic                   o_phlda,
  input  wire logic              i_hold_n
);

  // ---------------- power-on clear ----------------
  logic [POC_CW-1:0] poc_cnt_q;
  logic              poc_n_q;

  // restart the low time on every reset request
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      poc_cnt_q <= '0;
      poc_n_q   <= 1'b0;
    end else if (!i_reset_req_n) begin // RQ19
      poc_cnt_q <= '0;
      poc_n_q   <= 1'b0;
    end else if (!poc_n_q) begin
      if (poc_cnt_q == POC_CW'(POC_HOLD - 1)) begin
        poc_n_q <= 1'b1;
      end else begin
        poc_cnt_q <= poc_cnt_q + 1'b1;
      end
    end
  end

  assign o_poc_n       = poc_n_q; // RQ19 RQ17
  assign o_cpu_reset_n = poc_n_q;

  // ---------------- timing chain ----------------
  logic [REF_CW-1:0] ref_cnt_q;
  logic              ref_tick;
  logic              phase2_q;
  logic              bus_clk_q;
  logic              phi_tick;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      ref_cnt_q <= '0;
    end else if (ref_tick) begin
      ref_cnt_q <= '0;
    end else begin
      ref_cnt_q <= ref_cnt_q + 1'b1;
    end
  end

  assign ref_tick = (ref_cnt_q == REF_LAST); // RQ5

  // 4 MHz phase two toggles on every 8 MHz tick
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      phase2_q <= 1'b0;
    end else if (ref_tick) begin
      phase2_q <= ~phase2_q; // RQ7
    end
  end

  assign phi_tick = ref_tick & ~phase2_q;

  // 2 MHz clock: toggling on phase rise keeps it at 50 percent
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      bus_clk_q <= 1'b0;
    end else if (phi_tick) begin
      bus_clk_q <= ~bus_clk_q; // RQ6
    end
  end

  assign o_phase2     = phase2_q;
  assign o_bus_clock  = bus_clk_q;
  assign o_cpu_phi    = phase2_q;
  assign o_cpu_clk_en = phi_tick; // RQ5

  // ---------------- serial rate dividers ----------------
  logic [BAUD_CW-1:0] div_in [N_PORTS];
  logic [N_PORTS-1:0] rate_tick;
  logic [N_PORTS-1:0] sp_ref_q;

  assign div_in[0] = i_sp1_divisor;
  assign div_in[1] = i_sp2_divisor;

  for (genvar p = 0; p < N_PORTS; p++) begin : g_port
    logic [BAUD_CW-1:0] cnt_q;
    logic [BAUD_CW-1:0] div_q;
    logic               tick_q;

    // each port holds its own copy of the reference
    always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
        sp_ref_q[p] <= 1'b0;
      end else begin
        sp_ref_q[p] <= ref_tick; // RQ8
      end
    end

    // divisor is picked up only at a wrap, so a rewrite never glitches a bit
    always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
        cnt_q  <= '0;
        div_q  <= BAUD_RST_DIV;
        tick_q <= 1'b0;
      end else begin
        tick_q <= 1'b0;
        if (sp_ref_q[p]) begin
          if (cnt_q >= div_q) begin
            cnt_q  <= '0;
            div_q  <= div_in[p];
            tick_q <= 1'b1; // RQ8
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
      end
    end

    assign rate_tick[p] = tick_q;
  end

  assign o_serial_port_one_timing_ref = sp_ref_q[0];
  assign o_serial_port_two_timing_ref = sp_ref_q[1];
  assign o_sp1_rate_tick              = rate_tick[0];
  assign o_sp2_rate_tick              = rate_tick[1];

  // ---------------- bus hold ----------------
  logic busrq_n_q;
  logic phlda_q;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      busrq_n_q <= 1'b1;
      phlda_q   <= 1'b0;
    end else begin
      busrq_n_q <= i_hold_n;       // RQ18 RQ17
      phlda_q   <= ~i_cpu_busak_n; // RQ14
    end
  end

  assign o_cpu_busrq_n = busrq_n_q;
  assign o_phlda       = phlda_q;

  // ---------------- control latches ----------------
  logic              cyc_act;
  logic              cyc_act_q;
  logic              psync_q;
  logic              pwr_n_q;
  logic              pdbin_q;
  logic              mwrt_q;
  logic              own_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] do_q;

  assign cyc_act = ~i_cpu_mreq_n | ~i_cpu_iorq_n;

  // pSYNC stretches to the next reference tick for slow slaves
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cyc_act_q <= 1'b0;
      psync_q   <= 1'b0;
    end else begin
      cyc_act_q <= cyc_act;
      if (cyc_act & ~cyc_act_q) begin
        psync_q <= 1'b1; // RQ11
      end else if (ref_tick) begin
        psync_q <= 1'b0;
      end
    end
  end

  // strobes and write data latched on the same edge, so data-out is valid whenever pWR* is low
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      pwr_n_q <= 1'b1;
      pdbin_q <= 1'b0;
      mwrt_q  <= 1'b0;
      do_q    <= '0;
      addr_q  <= '0;
    end else begin
      addr_q  <= i_cpu_addr; // RQ9
      pdbin_q <= ~i_cpu_rd_n & cyc_act; // RQ13 RQ16
      pwr_n_q <= ~(~i_cpu_wr_n & i_cpu_dout_oe); // RQ12 RQ16
      mwrt_q  <= ~i_cpu_wr_n & i_cpu_dout_oe & ~i_cpu_mreq_n; // RQ15
      if (i_cpu_dout_oe) begin
        do_q <= i_cpu_dout; // RQ10
      end
    end
  end

  // buffers released while another master holds the bus
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      own_q <= 1'b0;
    end else begin
      own_q <= poc_n_q & i_cpu_busak_n; // RQ14 RQ9
    end
  end

  assign o_psync   = psync_q;
  assign o_pwr_n   = pwr_n_q;
  assign o_pdbin   = pdbin_q;
  assign o_mwrt    = mwrt_q;
  assign o_addr    = addr_q;
  assign o_do      = do_q;
  assign o_addr_oe = own_q; // RQ9
  assign o_do_oe   = own_q; // RQ10
  assign o_ctl_oe  = own_q;

  // ---------------- power-on jump ----------------
  ccb_jmp_t         jmp_q;
  logic [SW_W-1:0]  sw_q;
  logic             rd_act;
  logic             rd_act_q;
  logic             rd_end;
  logic [DATA_W-1:0] jmp_byte;
  logic [DATA_W-1:0] din_q;

  // switches caught while clear is held, frozen after release
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      sw_q <= '0;
    end else if (!poc_n_q) begin
      sw_q <= i_jump_option_switch; // RQ19
    end
  end

  assign rd_act = ~i_cpu_mreq_n & ~i_cpu_rd_n;
  assign rd_end = rd_act_q & ~rd_act;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rd_act_q <= 1'b0;
    end else begin
      rd_act_q <= rd_act;
    end
  end

  // three memory reads after clear are fed a jump instruction
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      jmp_q <= JMP_IDLE;
    end else if (!poc_n_q) begin
      jmp_q <= JMP_IDLE; // RQ19
    end else begin
      unique case (jmp_q)
        JMP_IDLE: begin
          jmp_q <= sw_q[SW_ENABLE] ? JMP_OP : JMP_DONE; // RQ3 RQ1
        end
        JMP_OP: begin
          if (rd_end) begin
            jmp_q <= JMP_LO;
          end
        end
        JMP_LO: begin
          if (rd_end) begin
            jmp_q <= JMP_HI;
          end
        end
        JMP_HI: begin
          if (rd_end) begin
            jmp_q <= JMP_DONE;
          end
        end
        JMP_DONE: begin
          jmp_q <= JMP_DONE;
        end
      endcase
    end
  end

  always_comb begin
    jmp_byte = i_di;
    unique case (jmp_q)
      JMP_OP:   jmp_byte = JMP_OPCODE; // RQ4
      JMP_LO:   jmp_byte = JMP_LOW; // RQ20
      JMP_HI:   jmp_byte = {sw_q[SW_ADDR_HI:0], JMP_NIBBLE}; // RQ2 RQ20
      JMP_IDLE: jmp_byte = i_di;
      JMP_DONE: jmp_byte = i_di;
    endcase
  end

  // internal data bus: read data from data-in buffers or jump circuit
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      din_q <= '0;
    end else if (~i_cpu_rd_n) begin
      din_q <= jmp_byte; // RQ10 RQ4
    end
  end

  assign o_cpu_din = din_q;

endmodule : ccb_master

`default_nettype wire

// ---- design/ccb_pkg.sv ----
// constants shared by the processor card bus master interface
package ccb_pkg;

  // system clock and reference
  localparam int unsigned SYS_CLK_HZ = 200_000_000;
  localparam int unsigned REF_HZ     = 8_000_000;
  localparam int unsigned REF_DIV    = SYS_CLK_HZ / REF_HZ;
  localparam int unsigned REF_CW     = 5;
  localparam logic [REF_CW-1:0] REF_LAST =
    REF_CW'(REF_DIV - 1);

  // power-on clear minimum low time
  localparam int unsigned POC_MIN_MS = 10;
  localparam int unsigned POC_CYCLES =
    (SYS_CLK_HZ / 1000) * POC_MIN_MS;
  localparam int unsigned POC_CW     = 22;

  // jump option switch layout
  localparam int unsigned SW_W       = 5;
  localparam int unsigned SW_ADDR_HI = 3;
  localparam int unsigned SW_ENABLE  = 4;

  // jump sequence bytes
  localparam logic [7:0]  JMP_OPCODE = 8'hC3;
  localparam logic [7:0]  JMP_LOW    = 8'h00;
  localparam logic [3:0]  JMP_NIBBLE = 4'h0;

  // serial line rate divider
  localparam int unsigned BAUD_CW    = 16;
  localparam logic [BAUD_CW-1:0] BAUD_RST_DIV = 16'h0034;
  localparam int unsigned N_PORTS    = 2;

  // bus widths
  localparam int unsigned ADDR_W     = 16;
  localparam int unsigned DATA_W     = 8;

  typedef enum logic [2:0] {
    JMP_IDLE,
    JMP_OP,
    JMP_LO,
    JMP_HI,
    JMP_DONE
  } ccb_jmp_t;

endpackage : ccb_pkg

// ---- dv/ccb_master_properties.sv ----
// checker for the bus master: timing chain, strobes, hold and power-on clear
`timescale 1ns/1ps
`default_nettype none
module ccb_master_properties
  import ccb_pkg::*;
(
  input wire logic              i_clock,
  input wire logic              i_nrst,
  input wire logic              i_reset_req_n,
  input wire logic [ADDR_W-1:0] i_cpu_addr,
  input wire logic              i_cpu_mreq_n,
  input wire logic              i_cpu_iorq_n,
  input wire logic              i_cpu_rd_n,
  input wire logic              i_cpu_wr_n,
  input wire logic              i_cpu_dout_oe,
  input wire logic              i_cpu_busak_n,
  input wire logic              o_poc_n,
  input wire logic              o_bus_clock,
  input wire logic              o_phase2,
  input wire logic              o_cpu_clk_en,
  input wire logic [ADDR_W-1:0] o_addr,
  input wire logic              o_addr_oe,
  input wire logic              o_psync,
  input wire logic              o_pwr_n,
  input wire logic              o_pdbin,
  input wire logic              o_mwrt,
  input wire logic              o_phlda
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  a_bus_clk_edge: assert property ($changed(o_bus_clock) |-> $rose(o_phase2))
    else $error("bus clock moved off a phase2 rise");
  a_phase2_hold: assert property ($changed(o_phase2) |=> !$changed(o_phase2) [*8])
    else $error("phase2 level too short");
  a_clk_en_rise: assert property (o_cpu_clk_en |=> $rose(o_phase2))
    else $error("processor enable not followed by phase2 rise");
  a_write_valid: assert property (!o_pwr_n |-> $past(!i_cpu_wr_n && i_cpu_dout_oe))
    else $error("write strobe without write data");
  a_mem_write: assert property (o_mwrt |-> !o_pwr_n && $past(!i_cpu_mreq_n))
    else $error("memory write outside memory write cycle");
  a_read_req: assert property (o_pdbin |-> $past(!i_cpu_rd_n && !(i_cpu_mreq_n && i_cpu_iorq_n)))
    else $error("read request without read cycle");
  a_sync_start: assert property ($fell(i_cpu_mreq_n) && i_cpu_busak_n |=> o_psync)
    else $error("cycle start not marked");
  a_hold_release: assert property (!i_cpu_busak_n |=> o_phlda && !o_addr_oe)
    else $error("bus not released on hold");
  a_addr_pass: assert property (o_addr_oe |-> o_addr == $past(i_cpu_addr))
    else $error("bus address differs from processor address");
  a_poc_req: assert property (!i_reset_req_n |=> !o_poc_n)
    else $error("reset request did not clear");
  a_poc_width: assert property ($fell(o_poc_n) |-> !o_poc_n [*8])
    else $error("power-on clear too short");
  c_hold: cover property (o_phlda);
  c_mwrt: cover property (o_mwrt);
  c_poc_end: cover property ($rose(o_poc_n));
endmodule : ccb_master_properties
bind ccb_master ccb_master_properties u_props (.i_clock, .i_nrst, .i_reset_req_n, .i_cpu_addr, .i_cpu_mreq_n,
  .i_cpu_iorq_n, .i_cpu_rd_n, .i_cpu_wr_n, .i_cpu_dout_oe, .i_cpu_busak_n, .o_poc_n, .o_bus_clock, .o_phase2,
  .o_cpu_clk_en, .o_addr, .o_addr_oe, .o_psync, .o_pwr_n, .o_pdbin, .o_mwrt, .o_phlda);
`default_nettype wire

// ---- dv/ccb_bus_board.sv ----
// backplane partner: memory slave and temporary master
`timescale 1ns/1ps
`default_nettype none
module ccb_bus_board
  import ccb_pkg::*;
(
  input  wire logic              i_clock,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic              i_pdbin,
  input  wire logic              i_take_bus,
  input  wire logic [DATA_W-1:0] i_do,
  input  wire logic              i_pwr_n,
  input  wire logic              i_do_oe,
  output logic [DATA_W-1:0]      o_di,
  output logic [DATA_W-1:0]      o_wr_data,
  output logic                   o_hold_n
);
  logic [DATA_W-1:0] last_q;
  always_ff @(posedge i_clock) begin
    if (i_pdbin) last_q <= o_di;
    // slave takes data-out only while the write strobe is low
    if (!i_pwr_n && i_do_oe) o_wr_data <= i_do;
  end
  // undriven lines show the inverse, so stale data cannot pass
  assign o_di = i_pdbin ? (i_addr[7:0] ^ 8'h5A) : ~last_q;
  assign o_hold_n = !i_take_bus;
endmodule : ccb_bus_board
`default_nettype wire

// ---- dv/testbench.sv ----
// self-checking bench for the bus master
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ccb_pkg::*;
  localparam int unsigned HOLD = 16;
  logic i_clock = 1'b0, i_nrst = 1'b0, i_reset_req_n = 1'b1, i_take = 1'b0;
  logic [4:0] i_jump_option_switch = 5'h00;
  logic [15:0] i_sp1_divisor = 16'h0002, i_sp2_divisor = 16'h0003, i_cpu_addr = 16'h0000;
  logic [7:0] i_cpu_dout = 8'h00;
  logic i_cpu_dout_oe = 1'b0, i_cpu_mreq_n = 1'b1, i_cpu_iorq_n = 1'b1, i_cpu_rd_n = 1'b1;
  logic i_cpu_wr_n = 1'b1, i_cpu_busak_n = 1'b1;
  wire logic [7:0] i_di, o_cpu_din, o_do, wr_data;
  wire logic [15:0] o_addr;
  wire logic i_hold_n, o_poc_n, o_bus_clock, o_phase2, o_cpu_clk_en, o_cpu_reset_n, o_cpu_busrq_n, o_cpu_phi;
  wire logic o_serial_port_one_timing_ref, o_serial_port_two_timing_ref, o_sp1_rate_tick, o_sp2_rate_tick;
  wire logic o_addr_oe, o_do_oe, o_ctl_oe, o_psync, o_pwr_n, o_pdbin, o_mwrt, o_phlda;
  int n_fail = 0;
  int compares = 0;
  ccb_master #(.POC_HOLD(HOLD)) i_dut (.i_clock, .i_nrst, .i_reset_req_n, .o_poc_n, .i_jump_option_switch,
    .i_sp1_divisor, .i_sp2_divisor, .o_bus_clock, .o_phase2, .o_cpu_phi, .o_cpu_clk_en,
    .o_serial_port_one_timing_ref, .o_serial_port_two_timing_ref, .o_sp1_rate_tick, .o_sp2_rate_tick,
    .o_cpu_reset_n, .i_cpu_addr, .i_cpu_dout, .i_cpu_dout_oe, .o_cpu_din, .i_cpu_mreq_n, .i_cpu_iorq_n,
    .i_cpu_rd_n, .i_cpu_wr_n, .i_cpu_busak_n, .o_cpu_busrq_n, .o_addr, .o_addr_oe, .i_di, .o_do, .o_do_oe,
    .o_ctl_oe, .o_psync, .o_pwr_n, .o_pdbin, .o_mwrt, .o_phlda, .i_hold_n);
  ccb_bus_board i_board (.i_clock, .i_addr(o_addr), .i_pdbin(o_pdbin), .i_take_bus(i_take), .i_do(o_do),
    .i_pwr_n(o_pwr_n), .i_do_oe(o_do_oe), .o_di(i_di), .o_wr_data(wr_data), .o_hold_n(i_hold_n));
  always #2.5 i_clock = ~i_clock;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  // reset by the async pin or by the bus request, then wait out the clear
  task automatic do_reset(input logic [4:0] sw, input logic by_req);
    int n;
    @(negedge i_clock);
    i_jump_option_switch = sw;
    if (by_req) i_reset_req_n = 1'b0;
    else i_nrst = 1'b0;
    repeat (3) @(negedge i_clock);
    chk(16'({o_poc_n, o_cpu_reset_n}), 16'h0);
    i_nrst = 1'b1;
    i_reset_req_n = 1'b1;
    n = 0;
    while (o_poc_n !== 1'b1 && n < 200) begin
      @(negedge i_clock);
      n++;
    end
    chk(16'(n >= HOLD && n < 200), 16'h1);
    if (n >= 200) give_verdict();
  endtask : do_reset
  task automatic bus_cycle(input logic io, input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(negedge i_clock);
    i_cpu_addr = a;
    i_cpu_dout = d;
    i_cpu_dout_oe = wr;
    i_cpu_mreq_n = io;
    i_cpu_iorq_n = !io;
    i_cpu_rd_n = wr;
    i_cpu_wr_n = !wr;
    @(negedge i_clock);
    chk(16'(o_psync), 16'h1);
    repeat (2) @(negedge i_clock);
    chk(o_addr, a);
  endtask : bus_cycle
  task automatic bus_end;
    @(negedge i_clock);
    {i_cpu_mreq_n, i_cpu_iorq_n, i_cpu_rd_n, i_cpu_wr_n, i_cpu_dout_oe} = 5'h1E;
    @(negedge i_clock);
  endtask : bus_end
  // three jump bytes when enabled, bus data otherwise and afterwards
  task automatic t_jump(input logic [4:0] sw, input logic by_req);
    logic [7:0] e;
    do_reset(sw, by_req);
    for (int i = 0; i < 4; i++) begin
      bus_cycle(1'b0, 1'b0, 16'h0010 + 16'(i), 8'h00);
      e = 8'h10 ^ 8'(i) ^ 8'h5A;
      if (sw[4] && i == 0) e = 8'hC3;
      if (sw[4] && i == 1) e = 8'h00;
      if (sw[4] && i == 2) e = {sw[3:0], 4'h0};
      chk(16'(o_cpu_din), 16'(e));
      chk(16'(o_pdbin), 16'h1);
      bus_end();
    end
  endtask : t_jump
  task automatic t_write;
    logic [7:0] wd;
    for (int io = 0; io < 2; io++) begin
      wd = 8'hA5 ^ 8'(io);
      bus_cycle(1'(io), 1'b1, 16'h1234, wd);
      chk(16'({o_pwr_n, o_mwrt, o_do_oe, o_do}), {5'h00, 1'b0, ~1'(io), 1'b1, wd});
      bus_end();
      chk(16'({o_pwr_n, o_mwrt}), 16'h2);
      chk(16'(wr_data), 16'(wd));
    end
  endtask : t_write
  task automatic t_hold;
    @(negedge i_clock);
    i_take = 1'b1;
    repeat (2) @(negedge i_clock);
    chk(16'(o_cpu_busrq_n), 16'h0);
    i_cpu_busak_n = 1'b0;
    repeat (2) @(negedge i_clock);
    chk(16'({o_phlda, o_addr_oe, o_do_oe, o_ctl_oe}), 16'h8);
    i_take = 1'b0;
    i_cpu_busak_n = 1'b1;
    repeat (2) @(negedge i_clock);
    chk(16'({o_phlda, o_cpu_busrq_n}), 16'h1);
  endtask : t_hold
  // divisors load only at wrap, so let the reset divisor run out first
  task automatic t_clocks;
    int c[9];
    int e[9];
    logic pb;
    c = '{default: 0};
    e = '{600, 600, 12, 24, 48, 48, 16, 12, 600};
    repeat (1400) @(negedge i_clock);
    pb = o_bus_clock;
    for (int i = 0; i < 1200; i++) begin
      @(negedge i_clock);
      c[0] += int'(o_bus_clock);
      c[1] += int'(o_phase2);
      c[2] += int'(o_bus_clock && !pb);
      c[3] += int'(o_cpu_clk_en);
      c[4] += int'(o_serial_port_one_timing_ref);
      c[5] += int'(o_serial_port_two_timing_ref);
      c[6] += int'(o_sp1_rate_tick);
      c[7] += int'(o_sp2_rate_tick);
      c[8] += int'(o_cpu_phi);
      pb = o_bus_clock;
    end
    for (int k = 0; k < 9; k++) chk(16'(c[k]), 16'(e[k]));
  endtask : t_clocks
  initial begin
    repeat (3) @(negedge i_clock);
    t_jump(5'h1A, 1'b0);
    t_write();
    t_hold();
    t_jump(5'h0A, 1'b1);
    t_jump(5'h15, 1'b0);
    t_clocks();
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
